/* File: verilog/drc_defs.svh */
// Purpose: Constants for the DRAM refresh control block
// Assumes: Classic Wishbone, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
// Behaviour
// - Bank-active clear: precharge after every access
// - Bank-active set, DRAM: row strobe held
// - Bank-active SDRAM only area 3; area 2 precharges
// - DRAM column width from two low mux bits
// - SDRAM geometry from three-bit mux code
// - Width select sets DRAM data width, ignores area
// - Refresh only while refresh enable set
// - Normal refresh issued at interval timer rate
// - Refresh waits for running external access end
// - Self refresh entered now or after SDRAM access
// - Timer requests discarded during self refresh
// - Control/status upper byte reads zero
// - Match flag set when counter equals constant
// - Flag clears by zero write after read
// - Interrupt only when match enable set
// - Tick select stops or divides peripheral clock
// - Burst count of refreshes per match
// - Counter clears on match, wraps after 255
// - Pending request held, replaced at next match
// - Interrupt held until flag clear; request kept
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_OFF_MEMCTL   4'h0
`define DRC_OFF_TMRCSR   4'h4
`define DRC_OFF_CNT      4'h8
`define DRC_OFF_CONST    4'hc
`define DRC_MEMCTL_RST   16'h0000
`define DRC_TMRCSR_RST   16'h0000
`define DRC_BIT_BANK_ACT 9
`define DRC_BIT_MUX_HI   7
`define DRC_BIT_WIDTH    6
`define DRC_BIT_MUX_MID  5
`define DRC_BIT_MUX_LO   4
`define DRC_BIT_REF_EN   3
`define DRC_BIT_REF_KIND 2
`define DRC_BIT_FLAG     7
`define DRC_BIT_IE       6
`define DRC_TICK_SEL_HI  5
`define DRC_TICK_SEL_LO  3
`define DRC_BURST_SEL_HI 2
`define DRC_BURST_SEL_LO 0
`define DRC_PRESC_W    12
`define DRC_CNT_MAX    8'hff
`endif

/* File: verilog/drc_pkg.sv */
// Purpose: Types for the DRAM refresh control block
// Assumes: Nothing beyond the defs header
// Notes:   Bundles carried between the core and the memory sequencer
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_IDLE  = 3'b001,
    DRC_BURST = 3'b010,
    DRC_SELF  = 3'b100
  } drc_state_t;

  typedef struct packed {
    logic       bank_active_hold;
    logic       row_strobe_hold;
    logic       sdram_auto_precharge;
    logic [3:0] col_addr_bits;
    logic [2:0] sdram_geometry;
    logic       geometry_reserved;
    logic       bus_is_32;
  } drc_cfg_t;

  typedef struct packed {
    logic refresh_cmd;
    logic self_refresh;
    logic busy;
  } drc_ref_t;
endpackage

/* File: verilog/drc_refresh_ctrl.sv */
// Purpose: Memory config decode, refresh interval timer and refresh issue
// Assumes: One peripheral clock; sequencer acknowledges each refresh
// Notes:   Registers on classic Wishbone; unmapped reads return zero
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "drc_defs.svh"
module drc_refresh_ctrl
  import drc_pkg::*;
#(
  parameter int PRESC_W = `DRC_PRESC_W
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_area_is_sdram,
  input  wire logic        i_area3,
  input  wire logic        i_ext_access,
  input  wire logic        i_sdram_access,
  input  wire logic        i_refresh_done,
  output drc_cfg_t         o_cfg,
  output drc_ref_t         o_ref,
  output logic             o_match_irq
);
  logic [15:0]        memctl_q, memctl_d;
  logic [7:0]         csr_q, csr_d;
  logic [7:0]         cnt_q, cnt_d, const_q, const_d;
  logic               rd_seen_q, rd_seen_d;
  logic               ack_q, ack_d;
  logic [31:0]        dat_q, dat_d;
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic               req_q, req_d;
  logic [3:0]         left_q, left_d;
  logic               cmd_q, cmd_d;
  drc_state_t         st_q, st_d;
  drc_cfg_t           cfg_q, cfg_d;
  logic               tick, match, wr, rd, self_req;
  logic [2:0]         tick_sel, burst_sel, addr_mux;
  logic [3:0]         burst_n;

  assign tick_sel  = csr_q[`DRC_TICK_SEL_HI:`DRC_TICK_SEL_LO];
  assign burst_sel = csr_q[`DRC_BURST_SEL_HI:`DRC_BURST_SEL_LO];
  assign addr_mux  = {memctl_q[`DRC_BIT_MUX_HI], memctl_q[`DRC_BIT_MUX_MID],
                      memctl_q[`DRC_BIT_MUX_LO]};
  assign wr  = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_q;
  assign rd  = i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_q;

  // Prescaler runs free so a select change never resets the phase
  always_comb begin
    presc_d = presc_q + 1'b1;
    case (tick_sel)
      3'd1:    tick = &presc_q[1:0];
      3'd2:    tick = &presc_q[3:0];
      3'd3:    tick = &presc_q[5:0];
      3'd4:    tick = &presc_q[7:0];
      3'd5:    tick = &presc_q[9:0];
      3'd6:    tick = &presc_q[10:0];
      3'd7:    tick = &presc_q[11:0];
      default: tick = 1'b0;
    endcase
  end

  assign match = (cnt_q == const_q);

  always_comb begin
    case (burst_sel)
      3'd0:    burst_n = 4'd1;
      3'd1:    burst_n = 4'd2;
      3'd2:    burst_n = 4'd4;
      3'd3:    burst_n = 4'd6;
      default: burst_n = 4'd8;
    endcase
  end

  // Register file and bus answer
  always_comb begin
    memctl_d  = memctl_q;
    csr_d     = csr_q;
    const_d   = const_q;
    rd_seen_d = rd_seen_q;
    ack_d     = i_wb_cyc & i_wb_stb & ~ack_q;
    dat_d     = dat_q;
    cnt_d     = cnt_q;
    if (tick) begin
      if (match || cnt_q == `DRC_CNT_MAX) begin
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    if (rd) begin
      case (i_wb_adr)
        `DRC_OFF_MEMCTL: dat_d = {16'h0000, memctl_q};
        `DRC_OFF_TMRCSR: dat_d = {24'h000000, csr_q};
        `DRC_OFF_CNT:   dat_d = {24'h000000, cnt_q};
        `DRC_OFF_CONST: dat_d = {24'h000000, const_q};
        default:        dat_d = 32'h00000000;
      endcase
      if (i_wb_adr == `DRC_OFF_TMRCSR && csr_q[`DRC_BIT_FLAG]) begin
        rd_seen_d = 1'b1;
      end
    end
    if (wr) begin
      case (i_wb_adr)
        `DRC_OFF_MEMCTL: begin
          if (i_wb_sel[0]) memctl_d[7:0] = i_wb_dat[7:0];
          if (i_wb_sel[1]) memctl_d[15:8] = i_wb_dat[15:8];
        end
        `DRC_OFF_TMRCSR: begin
          if (i_wb_sel[0]) begin
            csr_d[6:0] = i_wb_dat[6:0];
            if (!i_wb_dat[`DRC_BIT_FLAG] && rd_seen_q) begin
              csr_d[`DRC_BIT_FLAG] = 1'b0;
              rd_seen_d = 1'b0;
            end
          end
        end
        `DRC_OFF_CNT: begin
          if (i_wb_sel[0]) cnt_d = i_wb_dat[7:0];
        end
        `DRC_OFF_CONST: begin
          if (i_wb_sel[0]) const_d = i_wb_dat[7:0];
        end
        default: begin
        end
      endcase
    end
    if (tick && match) begin
      csr_d[`DRC_BIT_FLAG] = 1'b1;
    end
  end

  // Refresh scheduling
  assign self_req = memctl_q[`DRC_BIT_REF_EN] & memctl_q[`DRC_BIT_REF_KIND];
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    left_d = left_q;
    cmd_d  = 1'b0;
    if (tick && match && memctl_q[`DRC_BIT_REF_EN] && st_q != DRC_SELF) begin
      req_d = 1'b1;
    end
    if (!memctl_q[`DRC_BIT_REF_EN]) begin
      req_d = 1'b0;
    end
    case (st_q)
      DRC_IDLE: begin
        if (self_req && !i_sdram_access) begin
          st_d  = DRC_SELF;
          req_d = 1'b0;
        end else if (req_q && !self_req && !i_ext_access &&
                     memctl_q[`DRC_BIT_REF_EN]) begin
          st_d   = DRC_BURST;
          left_d = burst_n;
          req_d  = (tick && match) ? 1'b1 : 1'b0;
          cmd_d  = 1'b1;
        end
      end
      DRC_BURST: begin
        if (i_refresh_done) begin
          if (left_q <= 4'd1 || !memctl_q[`DRC_BIT_REF_EN]) begin
            st_d = DRC_IDLE;
          end else begin
            left_d = left_q - 4'd1;
            cmd_d  = 1'b1;
          end
        end
      end
      DRC_SELF: begin
        req_d = 1'b0;
        if (!self_req) begin
          st_d = DRC_IDLE;
        end
      end
      default: st_d = DRC_IDLE;
    endcase
  end

  // Configuration decode handed to the memory sequencer
  always_comb begin
    cfg_d = '0;
    cfg_d.bank_active_hold     = memctl_q[`DRC_BIT_BANK_ACT] & i_area_is_sdram & i_area3;
    cfg_d.row_strobe_hold      = memctl_q[`DRC_BIT_BANK_ACT] & ~i_area_is_sdram;
    cfg_d.sdram_auto_precharge = ~cfg_d.bank_active_hold;
    cfg_d.col_addr_bits        = 4'd8 + {2'b00, addr_mux[1:0]};
    cfg_d.sdram_geometry       = addr_mux;
    cfg_d.geometry_reserved    = i_area_is_sdram ? (addr_mux == 3'b110) : addr_mux[2];
    cfg_d.bus_is_32            = memctl_q[`DRC_BIT_WIDTH];
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      memctl_q  <= `DRC_MEMCTL_RST;
      csr_q     <= 8'h00;
      cnt_q     <= 8'h00;
      const_q   <= 8'h00;
      rd_seen_q <= 1'b0;
      ack_q     <= 1'b0;
      dat_q     <= 32'h00000000;
      presc_q   <= '0;
      req_q     <= 1'b0;
      left_q    <= 4'h0;
      cmd_q     <= 1'b0;
      st_q      <= DRC_IDLE;
      cfg_q     <= '0;
    end else begin
      memctl_q  <= memctl_d;
      csr_q     <= csr_d;
      cnt_q     <= cnt_d;
      const_q   <= const_d;
      rd_seen_q <= rd_seen_d;
      ack_q     <= ack_d;
      dat_q     <= dat_d;
      presc_q   <= presc_d;
      req_q     <= req_d;
      left_q    <= left_d;
      cmd_q     <= cmd_d;
      st_q      <= st_d;
      cfg_q     <= cfg_d;
    end
  end

  assign o_wb_ack          = ack_q;
  assign o_wb_dat          = dat_q;
  assign o_cfg             = cfg_q;
  // One driver for the whole bundle keeps strict tools content
  assign o_ref = '{refresh_cmd:  cmd_q,
                   self_refresh: (st_q == DRC_SELF),
                   busy:         (st_q == DRC_BURST)};
  // Interrupt follows the flag, so it stays up until software clears it
  assign o_match_irq = csr_q[`DRC_BIT_FLAG] & csr_q[`DRC_BIT_IE];
endmodule

/* File: dv/drc_refresh_ctrl_monitor.sv */
// Purpose: Port checks for the refresh control block
// Assumes: Sees the top module ports only
// Notes:   Bound after the module
`timescale 1ns/1ns
module drc_refresh_ctrl_monitor
  import drc_pkg::*;
#(
  parameter int PRESC_W = 12
) (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [3:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_area_is_sdram,
  input wire logic        i_area3,
  input wire logic        i_ext_access,
  input wire logic        i_sdram_access,
  input wire logic        i_refresh_done,
  input wire drc_cfg_t    o_cfg,
  input wire drc_ref_t    o_ref,
  input wire logic        o_match_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  sequence s_memctl; s_req ##0 (i_wb_we && i_wb_adr == 4'h0 && i_wb_sel == 4'hf); endsequence
  property p_ack; s_req |=> o_wb_ack; endproperty
  property p_ack1; o_wb_ack |=> !o_wb_ack; endproperty
  property p_wide; s_memctl |-> ##2 o_cfg.bus_is_32 == $past(i_wb_dat[6], 2); endproperty
  property p_row;
    (s_memctl ##1 !i_area_is_sdram [*2]) |-> o_cfg.row_strobe_hold == $past(i_wb_dat[9], 2);
  endproperty
  property p_ext; $rose(o_ref.busy) |-> !$past(i_ext_access); endproperty
  property p_cmd; o_ref.refresh_cmd |-> o_ref.busy ##1 !o_ref.refresh_cmd; endproperty
  property p_self; o_ref.self_refresh |-> !o_ref.refresh_cmd; endproperty
  property p_sdr; $rose(o_ref.self_refresh) |-> !$past(i_sdram_access); endproperty
  property p_irq; o_match_irq && !(i_wb_cyc && i_wb_we) |=> o_match_irq; endproperty
  property p_rsv; o_wb_ack && i_wb_adr == 4'h4 && !i_wb_we |-> o_wb_dat[31:8] == 24'h0; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_ack1: assert property (p_ack1) else $error("ack too long");
  a_wide: assert property (p_wide) else $error("bus width");
  a_row: assert property (p_row) else $error("row hold");
  a_ext: assert property (p_ext) else $error("refresh in access");
  a_cmd: assert property (p_cmd) else $error("refresh pulse");
  a_self: assert property (p_self) else $error("refresh in self");
  a_sdr: assert property (p_sdr) else $error("self too early");
  a_irq: assert property (p_irq) else $error("irq dropped");
  a_rsv: assert property (p_rsv) else $error("upper byte");
endmodule
bind drc_refresh_ctrl drc_refresh_ctrl_monitor #(.PRESC_W(PRESC_W)) u_mon (.*);

/* File: dv/drc_mem_model.sv */
// Purpose: Refresh sequencer and memory stand-in
// Assumes: One done pulse for each refresh command
// Notes:   Answer delay varies to catch timing slips
`timescale 1ns/1ns
module drc_mem_model (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_cmd,
  output logic      o_done
);
  int cnt;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 1);
      if (i_cmd) cnt <= 1 + $urandom_range(0, 3);
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule

/* File: dv/drc_refresh_ctrl_tb.sv */
// Purpose: Self-checking bench for the refresh control block
// Assumes: Partner model answers each refresh command
// Notes:   Small refresh constant keeps intervals short
`timescale 1ns/1ns
module drc_refresh_ctrl_tb;
  import drc_pkg::*;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic        sdr = 0, a3 = 0, ext = 0, sacc = 0, ext_en = 0, done, irq, ack, bq_q = 0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, wbo, m;
  drc_cfg_t    cfg;
  drc_ref_t    rf;
  int          errors = 0, comparisons = 0, n, pulses = 0;
  logic [31:0] rq[$], bq[$];
  always #25 clk = ~clk;
  drc_refresh_ctrl u_drc_refresh_ctrl (.i_ref_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(wbo), .o_wb_ack(ack), .i_area_is_sdram(sdr), .i_area3(a3),
    .i_ext_access(ext), .i_sdram_access(sacc), .i_refresh_done(done), .o_cfg(cfg),
    .o_ref(rf), .o_match_irq(irq));
  drc_mem_model u_drc_mem_model (.i_clk(clk), .i_nrst(nrst), .i_cmd(rf.refresh_cmd),
    .o_done(done));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    if (ack !== 1'b1) errors++;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Results are matched in arrival order, never by polling the driver
  always @(posedge clk) begin
    if (ack === 1'b1 && cyc && !we) chk("rdata", rq.size() ? rq.pop_front() : 32'hx, wbo);
    if (rf.refresh_cmd === 1'b1) pulses++;
    if (bq_q && rf.busy === 1'b0) begin
      chk("burst", bq.size() ? bq.pop_front() : 32'h0, pulses);
      pulses = 0;
    end
    bq_q = (rf.busy === 1'b1);
    ext <= ext_en && ($urandom % 4 == 0);
  end
  initial begin
    n = $urandom(32'hf646);
    wt(3);
    nrst <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h2, 32'h0);
    for (int c = 0; c < 16; c++) begin
      m = $urandom & 32'h240;
      if (c[3] && c[2:0] inside {1, 2, 5}) m[6] = 1'b1;
      m = m | {c[2], 1'b0, c[1:0], 4'h0};
      sdr <= c[3];
      a3 <= 1'($urandom);
      bus(4'h0, 1'b1, m);
      wt(3);
      chk("wide", m[6], cfg.bus_is_32);
      chk("bank", m[9] & c[3] & a3, cfg.bank_active_hold);
      chk("row", m[9] & !c[3], cfg.row_strobe_hold);
      chk("apre", !(m[9] & c[3] & a3), cfg.sdram_auto_precharge);
      if (c[3]) chk("geo", {c[2:0] == 6, c[2:0]}, {cfg.geometry_reserved, cfg.sdram_geometry});
      else chk("col", {c[2], 4'(8 + c[1:0])}, {cfg.geometry_reserved, cfg.col_addr_bits});
    end
    bus(4'hc, 1'b1, 32'd20);
    ext_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      bus(4'h0, 1'b1, 32'h0);
      bus(4'h4, 1'b1, 32'h08 | k);
      bq.push_back(k == 0 ? 1 : (k < 4 ? 2 * k : 8));
      bus(4'h0, 1'b1, 32'h08);
      n = 0;
      while (bq.size() && n++ < 3000) @(posedge clk);
      if (bq.size()) errors++;
    end
    bus(4'h0, 1'b1, 32'h0);
    ext_en = 1'b0;
    bus(4'h4, 1'b1, 32'h48);
    wt(2);
    chk("irq", 1, irq);
    // Restart the count so no match lands on the clear
    bus(4'h8, 1'b1, 32'h0);
    rd(4'h4, 32'hc8);
    bus(4'h4, 1'b1, 32'h48);
    wt(2);
    chk("irq", 0, irq);
    wt(100);
    chk("irq", 1, irq);
    bus(4'h4, 1'b1, 32'h0);
    chk("irq", 0, irq);
    bus(4'h8, 1'b1, 32'h7);
    wt(50);
    rd(4'h8, 32'h7);
    sacc <= 1'b1;
    bus(4'h0, 1'b1, 32'h0c);
    wt(4);
    chk("self", 0, rf.self_refresh);
    sacc <= 1'b0;
    wt(4);
    chk("self", 1, rf.self_refresh);
    bus(4'h4, 1'b1, 32'h08);
    wt(200);
    chk("selfq", 0, pulses);
    chk("self", 1, rf.self_refresh);
    bus(4'h0, 1'b1, 32'h0);
    wt(5);
    test_done();
  end
  initial begin
    #2000000;
    errors++;
    test_done();
  end
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
endmodule
